// *** pkg/sbe_pkg.sv ***
// Shared constants and types for the serial controller
package sbe_pkg;
  // ==========================================================
  // Widths and counts
  localparam int DATA_W = 8;
  localparam int NCS    = 4;
  localparam int DIV_W  = 8;
  localparam int FIFO_D = 2;
  // ==========================================================
  // Reset values and fixed codes
  localparam logic             EN_RST        = 1'b0;
  localparam logic             THR_EMPTY_RST = 1'b1;
  localparam logic [2:0]       NSS_SYNC_RST  = 3'h7;
  localparam logic [DIV_W-1:0] DIV_ONE       = 8'h01;
  // ==========================================================
  // Transfer sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_EXTRA, ST_XFER, ST_DONE} sbe_state_t;
endpackage

// *** pkg/sbe_strm_if.sv ***
// Valid/ready word stream between the controller and its receive buffer
`timescale 1ns/1ps
interface sbe_strm_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface

// *** logic/sbe_fifo2.sv ***
// Small valid/ready buffer on the receive data path
`timescale 1ns/1ps
module sbe_fifo2 #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  input  logic clk_sys,
  input  logic rst,
  sbe_strm_if.dst in_s,
  sbe_strm_if.src out_s
);
  import sbe_pkg::*;

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
  } sbe_fifo_st_t;

  sbe_fifo_st_t r;
  sbe_fifo_st_t n;
  logic         do_wr;
  logic         do_rd;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // ==========================================================
  // Handshakes: full and empty come straight from the count
  assign in_s.ready  = (r.cnt != (AW+1)'(DEPTH));
  assign out_s.valid = (r.cnt != '0);
  assign out_s.data  = r.mem[r.rp];
  assign do_wr       = in_s.valid && in_s.ready;
  assign do_rd       = out_s.valid && out_s.ready;

  // Next state
  always_comb begin
    n = r;
    if (do_wr) begin
      n.mem[r.wp] = in_s.data;
      n.wp        = ptr_inc(r.wp);
    end
    if (do_rd) begin
      n.rp = ptr_inc(r.rp);
    end
    if (do_wr && !do_rd) begin
      n.cnt = r.cnt + 1'b1;
    end else if (do_rd && !do_wr) begin
      n.cnt = r.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule

// *** logic/sbe_spi.sv ***
// Serial peripheral controller with its known faulty behaviours kept
`timescale 1ns/1ps
module sbe_spi #(
  parameter int W   = sbe_pkg::DATA_W,
  parameter int NCS = sbe_pkg::NCS
) (
  input  logic                                 clk_sys,
  input  logic                                 rst,
  input  logic                                 enable_cmd,
  input  logic                                 disable_cmd,
  input  logic                                 soft_reset_command,
  input  logic                                 master_mode,
  input  logic                                 mode_fault_disable,
  input  logic                                 mode_fault_clear,
  input  logic                                 overrun_clear,
  input  logic [$clog2(NCS)-1:0]               cs_sel,
  input  logic [NCS-1:0]                       cs_active_after_transfer,
  input  logic [NCS-1:0]                       clk_polarity,
  input  logic [NCS-1:0]                       inverted_clock_phase,
  input  logic [NCS-1:0][sbe_pkg::DIV_W-1:0]   baud_divisor,
  input  logic                                 tdr_wr,
  input  logic [W-1:0]                         tdr_wdata,
  output logic                                 tx_holding_empty,
  output logic                                 tx_word_lost,
  output logic                                 enabled,
  output logic                                 mode_fault,
  output logic                                 overrun,
  output logic                                 busy,
  output logic                                 xfer_stalled,
  output logic [W-1:0]                         rx_data,
  output logic                                 rx_valid,
  input  logic                                 rx_ready,
  input  logic                                 sck_i,
  output logic                                 sck_o,
  output logic                                 sck_oe_n,
  input  logic                                 mosi_i,
  output logic                                 mosi_o,
  output logic                                 mosi_oe_n,
  input  logic                                 miso_i,
  output logic                                 miso_o,
  output logic                                 miso_oe_n,
  input  logic                                 nss_i,
  output logic [NCS-1:0]                       cs_n_o
);
  import sbe_pkg::*;

  localparam int CSW = $clog2(NCS);
  localparam int EW  = $clog2(2 * W) + 1;

  typedef struct packed {
    sbe_state_t       st;
    logic             en;
    logic             mfault;
    logic             ovr;
    logic             lost;
    logic [W-1:0]     thr;
    logic             thr_empty;
    logic [W-1:0]     tsh;
    logic [W-1:0]     rsh;
    logic [EW-1:0]    ecnt;
    logic             wdone;
    logic [DIV_W-1:0] dcnt;
    logic             sck;
    logic             cs_on;
    logic [CSW-1:0]   cur;
    logic [2:0]       s_sck;
    logic [2:0]       s_mosi;
    logic [2:0]       s_miso;
    logic [2:0]       s_nss;
    logic             push;
    logic [W-1:0]     pdata;
  } sbe_st_t;

  sbe_st_t r;
  sbe_st_t n;

  sbe_strm_if #(.W(W)) rx_in ();
  sbe_strm_if #(.W(W)) rx_out ();

  // ==========================================================
  // Helpers
  // Any divisor at one while another is not: the faulty combination
  function automatic logic mixed_div(input logic [NCS-1:0][DIV_W-1:0] d);
    logic any_one;
    logic any_other;
    any_one   = 1'b0;
    any_other = 1'b0;
    for (int i = 0; i < NCS; i++) begin
      if (d[i] == DIV_ONE) begin
        any_one = 1'b1;
      end else begin
        any_other = 1'b1;
      end
    end
    mixed_div = any_one && any_other;
  endfunction

  // Divisor zero would never tick, so it counts as one
  function automatic logic [DIV_W-1:0] div_eff(input logic [DIV_W-1:0] d);
    div_eff = (d == '0) ? DIV_ONE : d;
  endfunction

  // ==========================================================
  // Decoded conditions
  logic stall_cs0;
  logic m_tick;
  logic cpha_n;
  logic slv_act;
  logic s_edge;
  logic s_lead;
  logic s_sample;
  logic extra_req;

  // Fault detect left on with CS0 hold-select: no master word ever starts
  assign stall_cs0 = cs_active_after_transfer[0] && !mode_fault_disable;
  assign m_tick    = (r.dcnt == div_eff(baud_divisor[r.cur]) - DIV_ONE);
  assign cpha_n    = inverted_clock_phase[r.cur];
  assign slv_act   = !master_mode && r.en && !r.s_nss[1];
  assign s_edge    = r.s_sck[1] != r.s_sck[2];
  assign s_lead    = r.s_sck[1] != clk_polarity[0];
  assign s_sample  = (s_lead == inverted_clock_phase[0]);
  assign extra_req = (NCS > 1) && mixed_div(baud_divisor) && clk_polarity[cs_sel]
                     && !inverted_clock_phase[cs_sel];

  // ==========================================================
  // Next state
  always_comb begin
    n        = r;
    n.s_sck  = {r.s_sck[1:0], sck_i};
    n.s_mosi = {r.s_mosi[1:0], mosi_i};
    n.s_miso = {r.s_miso[1:0], miso_i};
    n.s_nss  = {r.s_nss[1:0], nss_i};
    n.push   = 1'b0;
    n.lost   = 1'b0;

    // Enable and disable; slave mode simply ignores the disable
    if (enable_cmd) begin
      n.en = 1'b1;
    end
    if (disable_cmd && master_mode) begin
      n.en = 1'b0;
    end

    // Another master pulling select low while we master
    if (mode_fault_clear) begin
      n.mfault = 1'b0;
    end
    if (master_mode && r.en && !mode_fault_disable && !r.s_nss[1]) begin
      n.mfault = 1'b1;
      n.en     = 1'b0;
    end
    if (overrun_clear) begin
      n.ovr = 1'b0;
    end

    // Master sequencer
    unique case (r.st)
      ST_IDLE: begin
        if (!r.en || !master_mode) begin
          n.cs_on = 1'b0;
        end else if (!r.thr_empty && rx_in.ready && !stall_cs0) begin
          n.cur       = cs_sel;
          n.tsh       = r.thr;
          n.thr_empty = 1'b1;
          n.cs_on     = 1'b1;
          n.ecnt      = '0;
          n.dcnt      = '0;
          n.sck       = clk_polarity[cs_sel];
          n.st        = extra_req ? ST_EXTRA : ST_XFER;
        end
      end
      ST_EXTRA: begin
        // One spurious clock period ahead of the data bits
        n.dcnt = m_tick ? '0 : r.dcnt + DIV_ONE;
        if (m_tick) begin
          n.sck  = !r.sck;
          n.ecnt = r.ecnt + 1'b1;
          if (r.ecnt == EW'(1)) begin
            n.ecnt = '0;
            n.st   = ST_XFER;
          end
        end
      end
      ST_XFER: begin
        n.dcnt = m_tick ? '0 : r.dcnt + DIV_ONE;
        if (m_tick) begin
          n.sck  = !r.sck;
          n.ecnt = r.ecnt + 1'b1;
          if (r.ecnt[0] == !cpha_n) begin
            n.rsh = {r.rsh[W-2:0], r.s_miso[1]};
          end else if (cpha_n || r.ecnt != '0) begin
            n.tsh = {r.tsh[W-2:0], 1'b0};
          end
          if (r.ecnt == EW'(2 * W - 1)) begin
            n.st = ST_DONE;
          end
        end
      end
      ST_DONE: begin
        // Room was checked at start, but the previous word's push can fill the buffer in that start cycle, so this push can be lost
        n.push  = 1'b1;
        n.pdata = r.rsh;
        n.cs_on = cs_active_after_transfer[r.cur];
        n.st    = ST_IDLE;
      end
    endcase

    // Losing enable mid-word aborts the master word
    if ((r.st != ST_IDLE) && !r.en) begin
      n.st    = ST_IDLE;
      n.cs_on = 1'b0;
      n.push  = 1'b0;
    end

    // Slave path on the sampled link clock
    if (slv_act) begin
      if (r.s_nss[2] && !r.s_nss[1]) begin
        n.tsh       = r.thr_empty ? '0 : r.thr;
        n.thr_empty = 1'b1;
        n.ecnt      = '0;
        n.wdone     = 1'b0;
      end else if (s_edge && s_sample) begin
        n.rsh  = {r.rsh[W-2:0], r.s_mosi[1]};
        n.ecnt = r.ecnt + 1'b1;
        if (r.ecnt == EW'(W - 1)) begin
          n.ecnt  = '0;
          n.wdone = 1'b1;
          // A slave cannot stall its master: a full buffer drops the word
          if (rx_in.ready) begin
            n.push  = 1'b1;
            n.pdata = {r.rsh[W-2:0], r.s_mosi[1]};
          end else begin
            n.ovr = 1'b1;
          end
        end
      end else if (s_edge && r.wdone) begin
        n.tsh       = r.thr_empty ? '0 : r.thr;
        n.thr_empty = 1'b1;
        n.wdone     = 1'b0;
      end else if (s_edge && (inverted_clock_phase[0] || r.ecnt != '0)) begin
        n.tsh = {r.tsh[W-2:0], 1'b0};
      end
    end

    // Data writes last so a write in the load cycle is kept;
    // while disabled they vanish and the empty flag stays put
    if (tdr_wr) begin
      if (r.en) begin
        n.thr       = tdr_wdata;
        n.thr_empty = 1'b0;
      end else begin
        n.lost = 1'b1;
      end
    end
  end

  // ==========================================================
  // State register; soft reset is as strong as the reset pin
  always_ff @(posedge clk_sys) begin
    if (rst || soft_reset_command) begin
      r           <= '0;
      r.en        <= EN_RST;
      r.thr_empty <= THR_EMPTY_RST;
      r.s_nss     <= NSS_SYNC_RST;
    end else begin
      r <= n;
    end
  end

  // ==========================================================
  // Receive buffer
  assign rx_in.valid  = r.push;
  assign rx_in.data   = r.pdata;
  assign rx_out.ready = rx_ready;
  assign rx_valid     = rx_out.valid;
  assign rx_data      = rx_out.data;

  sbe_fifo2 #(
    .W     (W),
    .DEPTH (FIFO_D)
  ) u_rx_buf (
    .clk_sys (clk_sys),
    .rst     (rst || soft_reset_command),
    .in_s    (rx_in),
    .out_s   (rx_out)
  );

  // ==========================================================
  // Status and pins
  assign tx_holding_empty = r.thr_empty;
  assign tx_word_lost     = r.lost;
  assign enabled          = r.en;
  assign mode_fault       = r.mfault;
  assign overrun          = r.ovr;
  assign busy             = (r.st != ST_IDLE);
  assign xfer_stalled     = stall_cs0 && r.en && master_mode && !r.thr_empty;
  assign sck_o            = busy ? r.sck : clk_polarity[r.cur];
  assign sck_oe_n         = !(master_mode && r.en);
  assign mosi_o           = r.tsh[W-1];
  assign mosi_oe_n        = !(master_mode && r.en);
  assign miso_o           = r.tsh[W-1];
  assign miso_oe_n        = !slv_act;

  // Selects are active low, one at a time
  always_comb begin
    for (int i = 0; i < NCS; i++) begin
      cs_n_o[i] = !(r.cs_on && (r.cur == CSW'(i)));
    end
  end
endmodule

// *** verification/sbe_spi_properties.sv ***
// Concurrent checks on the serial controller ports
`timescale 1ns/1ps
module sbe_spi_chk #(
  parameter int NCS = 4
) (
  input logic           clk_sys,
  input logic           rst,
  input logic           enable_cmd,
  input logic           disable_cmd,
  input logic           soft_reset_command,
  input logic           master_mode,
  input logic           mode_fault_disable,
  input logic [NCS-1:0] cs_active_after_transfer,
  input logic           tdr_wr,
  input logic           tx_holding_empty,
  input logic           tx_word_lost,
  input logic           enabled,
  input logic           mode_fault,
  input logic           overrun,
  input logic           busy,
  input logic           xfer_stalled,
  input logic           rx_valid,
  input logic [NCS-1:0] cs_n_o
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ==========================================================
  // Soft reset followed by a quiet cycle
  sequence s_srst_quiet;
    soft_reset_command ##1 !enable_cmd;
  endsequence
  AST_STALL: assert property (
    !busy && cs_active_after_transfer[0] && !mode_fault_disable |=> !busy)
    else $error("word started under hold select");
  AST_STALL_FLAG: assert property (
    enabled && master_mode && cs_active_after_transfer[0] && !mode_fault_disable
    && !tx_holding_empty && !busy |-> xfer_stalled)
    else $error("stall flag missing");
  AST_DROP: assert property (
    tdr_wr && !enabled && !soft_reset_command
    |=> tx_word_lost && tx_holding_empty == $past(tx_holding_empty))
    else $error("write while disabled was not dropped");
  AST_LOST: assert property (
    tx_word_lost |-> $past(tdr_wr) && !$past(enabled))
    else $error("lost pulse without a dropped write");
  AST_SLAVE_KEEP: assert property (
    enabled && !master_mode && disable_cmd && !soft_reset_command |=> enabled)
    else $error("slave disable took effect");
  AST_MASTER_DIS: assert property (
    master_mode && disable_cmd && !enable_cmd && !soft_reset_command |=> !enabled)
    else $error("master disable ignored");
  AST_SRST: assert property (
    soft_reset_command |=> !enabled && tx_holding_empty && !busy && !rx_valid
    && (&cs_n_o) && !mode_fault && !overrun)
    else $error("soft reset left state behind");
  AST_SRST_HOLD: assert property (
    s_srst_quiet |=> !enabled && tx_holding_empty)
    else $error("controller woke after soft reset");
endmodule
bind sbe_spi sbe_spi_chk #(.NCS(NCS)) chk_u (
  .clk_sys, .rst, .enable_cmd, .disable_cmd, .soft_reset_command, .master_mode,
  .mode_fault_disable, .cs_active_after_transfer, .tdr_wr, .tx_holding_empty,
  .tx_word_lost, .enabled, .mode_fault, .overrun, .busy, .xfer_stalled,
  .rx_valid, .cs_n_o
);

// *** verification/sbe_slave_model.sv ***
// Far-end slave device answering the controller with a fixed byte
`timescale 1ns/1ps
module sbe_slave_model #(
  parameter logic [7:0] REPLY = 8'h3c
) (
  input  logic sck,
  input  logic cs_n,
  input  logic       cpol,
  input  logic       mosi,
  output logic       miso,
  output logic [7:0] got
);
  logic [7:0] shift_r = 8'h00;
  logic       last_r  = 1'b0;
  // Load on select, then shift MSB first on each trailing edge
  always @(negedge cs_n)
    shift_r = REPLY;
  always @(sck)
    if (!cs_n && sck === cpol)
      shift_r = {shift_r[6:0], 1'b0};
  // Released line shows the inverse so a stale bit never passes as good data
  always @(posedge cs_n)
    last_r = shift_r[7];
  // Capture what the controller sends, on leading edges, fresh per select
  always @(negedge cs_n)
    got = 8'h00;
  always @(sck)
    if (!cs_n && sck !== cpol)
      got = {got[6:0], mosi};
  assign miso = cs_n ? ~last_r : shift_r[7];
endmodule

// *** verification/tb.sv ***
// Self-checking bench for the serial controller
`timescale 1ns/1ps
module tb;
  import sbe_pkg::*;
  logic clk_sys = 0, rst = 1, enable_cmd = 0, disable_cmd = 0, soft_reset_command = 0;
  logic master_mode = 1, mode_fault_disable = 0, mode_fault_clear = 0, overrun_clear = 0;
  logic tdr_wr = 0, rx_ready = 0, sck_i = 0, mosi_i = 0, nss_i = 1, sck_q = 0;
  logic [1:0] cs_sel = 0;
  logic [NCS-1:0] cs_active_after_transfer = 0, clk_polarity = 0;
  logic [NCS-1:0] inverted_clock_phase = 4'hf, cs_n_o;
  logic [NCS-1:0][DIV_W-1:0] baud_divisor = {NCS{8'h04}};
  logic [7:0] tdr_wdata = 0, rx_data, got;
  logic tx_holding_empty, tx_word_lost, enabled, mode_fault, overrun, busy;
  logic xfer_stalled, rx_valid, sck_o, sck_oe_n, mosi_o, mosi_oe_n, miso_i, miso_o, miso_oe_n;
  int n_fail = 0, check_count = 0, cyc = 0, falls = 0;
  sbe_spi dut_u (.clk_sys, .rst, .enable_cmd, .disable_cmd, .soft_reset_command,
    .master_mode, .mode_fault_disable, .mode_fault_clear, .overrun_clear, .cs_sel,
    .cs_active_after_transfer, .clk_polarity, .inverted_clock_phase, .baud_divisor,
    .tdr_wr, .tdr_wdata, .tx_holding_empty, .tx_word_lost, .enabled, .mode_fault,
    .overrun, .busy, .xfer_stalled, .rx_data, .rx_valid, .rx_ready, .sck_i, .sck_o,
    .sck_oe_n, .mosi_i, .mosi_o, .mosi_oe_n, .miso_i, .miso_o, .miso_oe_n, .nss_i, .cs_n_o);
  sbe_slave_model model_u (.sck(sck_o), .cs_n(cs_n_o[1]), .cpol(clk_polarity[1]),
    .mosi(mosi_o), .miso(miso_i), .got(got));
  // ==========================================================
  // Clock, falling-edge count on the serial clock, hang guard
  initial forever #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (busy && sck_q && !sck_o) falls++;
    sck_q = sck_o;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ==========================================================
  // Shared helpers; inputs move 10 ns after the edge
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #10;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    step(1);
    s = 0;
  endtask
  task automatic wr(input logic [7:0] d);
    tdr_wdata = d;
    pulse(tdr_wr);
  endtask
  task automatic wait_rx;
    for (int i = 0; i < 400 && rx_valid !== 1'b1; i++)
      step(1);
    chk("rx_valid", rx_valid, 1);
  endtask
  task automatic pop;
    wait_rx();
    pulse(rx_ready);
    // Let an edge pass so a following pop never re-raises ready in one step
    step(1);
  endtask
  task automatic settle;
    for (int i = 0; i < 400 && (busy !== 1'b0 || tx_holding_empty !== 1'b1); i++)
      step(1);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset;
    chk("empty", tx_holding_empty, 1);
    chk("enabled", enabled, 0);
    chk("cs_n", cs_n_o, 8'h0f);
  endtask
  task automatic t_drop;
    wr(8'ha5);
    chk("lost", tx_word_lost, 1);
    chk("empty", tx_holding_empty, 1);
  endtask
  task automatic t_stall;
    cs_active_after_transfer = 4'h1;
    cs_sel = 2'h1;
    pulse(enable_cmd);
    wr(8'h96);
    step(20);
    chk("stalled", xfer_stalled, 1);
    chk("busy", busy, 0);
    chk("cs_n", cs_n_o, 8'h0f);
    mode_fault_disable = 1;
    wait_rx();
    chk("rx_data", rx_data, 8'h3c);
    chk("mosi", got, 8'h96);
    pop();
  endtask
  task automatic t_extra;
    cs_active_after_transfer = 0;
    clk_polarity[2] = 1;
    inverted_clock_phase[2] = 0;
    baud_divisor[2] = DIV_ONE;
    cs_sel = 2'h2;
    falls = 0;
    wr(8'h81);
    settle();
    chk("sck falls", 8'(falls), 9);
    baud_divisor = {NCS{DIV_ONE}};
    falls = 0;
    wr(8'h7e);
    settle();
    chk("sck falls", 8'(falls), 8);
    wr(8'h42);
    step(60);
    chk("busy", busy, 0);
    chk("empty", tx_holding_empty, 0);
    repeat (3) pop();
  endtask
  task automatic t_dis;
    baud_divisor = {NCS{8'h04}};
    cs_sel = 2'h1;
    wr(8'h33);
    step(12);
    chk("busy", busy, 1);
    chk("sck_oe_n", sck_oe_n, 0);
    chk("mosi_oe_n", mosi_oe_n, 0);
    pulse(disable_cmd);
    chk("enabled", enabled, 0);
    tdr_wr = 1;
    step(1);
    chk("lost", tx_word_lost, 1);
    step(1);
    chk("lost", tx_word_lost, 1);
    tdr_wr = 0;
    step(100);
    chk("rx_valid", rx_valid, 0);
    chk("empty", tx_holding_empty, 1);
    // Resume in the safe order: controller first, then the writer
    pulse(enable_cmd);
    wr(8'h66);
    chk("empty", tx_holding_empty, 0);
    wait_rx();
    chk("rx_data", rx_data, 8'h3c);
    chk("mosi", got, 8'h66);
    pop();
    // Another master pulls select low while detection is on
    mode_fault_disable = 0;
    nss_i = 0;
    step(3);
    chk("mode_fault", mode_fault, 1);
    chk("enabled", enabled, 0);
    chk("sck_oe_n", sck_oe_n, 1);
    nss_i = 1;
    pulse(mode_fault_clear);
    chk("mode_fault", mode_fault, 0);
  endtask
  task automatic t_slave;
    logic [7:0] v;
    logic [7:0] w;
    v = 8'hc3;
    w = 8'h00;
    pulse(soft_reset_command);
    chk("enabled", enabled, 0);
    master_mode = 0;
    pulse(enable_cmd);
    wr(8'h5a);
    nss_i = 0;
    pulse(disable_cmd);
    chk("enabled", enabled, 1);
    // Link clock of 800 ns, with select held low for the frame
    for (int i = 7; i >= 0; i--) begin
      mosi_i = v[i];
      step(4);
      w = {w[6:0], miso_o};
      sck_i = 1;
      step(4);
      sck_i = 0;
    end
    mosi_i = ~mosi_i;
    chk("miso_oe_n", miso_oe_n, 0);
    chk("miso_o", w, 8'h5a);
    wait_rx();
    chk("rx_data", rx_data, 8'hc3);
    chk("overrun", overrun, 0);
    pulse(rx_ready);
    nss_i = 1;
    pulse(soft_reset_command);
    chk("enabled", enabled, 0);
    chk("empty", tx_holding_empty, 1);
    // Two more edges so the soft reset checks get to look
    step(2);
  endtask
  initial begin
    step(20);
    rst = 0;
    step(1);
    t_reset();
    t_drop();
    t_stall();
    t_extra();
    t_dis();
    t_slave();
    summarize();
  end
endmodule
